// File: design/scrb_bank.sv
// Control register bank of the frequency synthesiser, on the serial register port.
`timescale 1ns/1ps
`default_nettype none
module scrb_bank
  import scrb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register port from the serial interface state machine.
  input wire logic [7:0] regAddr,
  input wire logic regWrStb,
  input wire logic [7:0] regWrData,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  output logic serialAbort,
  // Synthesis loop.
  output logic [31:0] altReferenceFreqWord,
  output logic newFrequencyStrobe,
  input wire logic newFreqApplied,
  output logic holdSynthLoop,
  // Control-voltage converter.
  input wire logic [CV_W-1:0] cvSample,
  output logic [CV_W-1:0] cvWord,
  // Nonvolatile store.
  output logic nvReadReq,
  input wire logic [31:0] nvFreqWord,
  // Clock output driver.
  output logic clkOutOe
);

  localparam int SOFT_MAX = SOFT_RST_CYC + 3;
  localparam int RELOAD_MAX = RELOAD_CYC + 3;
  localparam scrb_state_t STATE_RST = '{
    freq: FREQ_RST,
    softRst: CTRL_RST[BIT_SOFT_RST],
    freqStrobe: CTRL_RST[BIT_NEW_FREQ],
    holdMult: CTRL_RST[BIT_HOLD_MULT],
    holdCv: CTRL_RST[BIT_HOLD_CV],
    reload: CTRL_RST[BIT_RELOAD],
    loopHold: LOOP_RST[BIT_LOOP_HOLD],
    multWord: FREQ_RST,
    cvWord: '0,
    rdData: 8'h00
  };

  scrb_state_t q_ff;
  scrb_state_t nxt_q;
  logic wrAllowed;
  logic ctrlWr;
  logic loopWr;

  scrb_seq_if seqBus ();

  scrb_seq u_seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .sq(seqBus.seq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read decode.

  function automatic logic [7:0] readReg(input scrb_state_t s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      ADDR_FREQ3: r = s.freq[31:24];
      ADDR_FREQ2: r = s.freq[23:16];
      ADDR_FREQ1: r = s.freq[15:8];
      ADDR_FREQ0: r = s.freq[7:0];
      ADDR_CTRL: begin
        r[BIT_SOFT_RST] = s.softRst;
        r[BIT_NEW_FREQ] = s.freqStrobe;
        r[BIT_HOLD_MULT] = s.holdMult;
        r[BIT_HOLD_CV] = s.holdCv;
        r[BIT_RELOAD] = s.reload;
      end
      ADDR_LOOP: r[BIT_LOOP_HOLD] = s.loopHold;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : readReg

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // The serial machine is aborted during a soft reset, so any write it
  // still presents then is dropped rather than half applied.
  assign wrAllowed = regWrStb && !q_ff.softRst;
  assign ctrlWr = wrAllowed && (regAddr == ADDR_CTRL);
  assign loopWr = wrAllowed && (regAddr == ADDR_LOOP);

  always_comb begin
    nxt_q = q_ff;

    // Words delivered to the analogue side follow their sources unless held.
    if (!q_ff.holdMult) begin
      nxt_q.multWord = q_ff.freq;
    end
    if (!q_ff.holdCv) begin
      nxt_q.cvWord = cvSample;
    end

    // Hardware clears come first so that a host write in the same cycle wins.
    if (newFreqApplied) begin
      nxt_q.freqStrobe = 1'b0;
    end
    if (seqBus.reloadDone) begin
      nxt_q.freq = nvFreqWord;
      nxt_q.reload = 1'b0;
    end
    if (seqBus.softDone) begin
      nxt_q.softRst = 1'b0;
    end

    if (wrAllowed) begin
      unique case (regAddr)
        ADDR_FREQ3: nxt_q.freq[31:24] = regWrData;
        ADDR_FREQ2: nxt_q.freq[23:16] = regWrData;
        ADDR_FREQ1: nxt_q.freq[15:8] = regWrData;
        ADDR_FREQ0: nxt_q.freq[7:0] = regWrData;
        ADDR_CTRL: begin
          nxt_q.freqStrobe = regWrData[BIT_NEW_FREQ] | (q_ff.freqStrobe & !newFreqApplied);
          nxt_q.holdMult = regWrData[BIT_HOLD_MULT];
          nxt_q.holdCv = regWrData[BIT_HOLD_CV];
          // A written zero leaves a reload in flight untouched.
          if (regWrData[BIT_RELOAD]) begin
            nxt_q.reload = 1'b1;
          end
        end
        ADDR_LOOP: nxt_q.loopHold = regWrData[BIT_LOOP_HOLD];
        default: begin
        end
      endcase
    end

    // Soft reset puts every field except rdData loaded by a same-cycle read back to its reset value at once;
    // only the bit itself stays up until the sequence ends.
    if (ctrlWr && regWrData[BIT_SOFT_RST]) begin
      nxt_q = STATE_RST;
      nxt_q.softRst = 1'b1;
    end

    if (regRdStb) begin
      nxt_q.rdData = readReg(q_ff, regAddr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_ff <= STATE_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign seqBus.softReq = q_ff.softRst;
  assign seqBus.reloadReq = q_ff.reload;

  assign regRdData = q_ff.rdData;
  assign serialAbort = q_ff.softRst;
  // The reload never touches the serial machine.
  assign nvReadReq = seqBus.inReload;
  assign altReferenceFreqWord = q_ff.multWord;
  assign newFrequencyStrobe = q_ff.freqStrobe;
  assign holdSynthLoop = q_ff.loopHold;
  assign cvWord = q_ff.cvWord;
  // The output driver is released for the whole soft reset.
  assign clkOutOe = !q_ff.softRst;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_freq_byte_wr: assert property (@(posedge ref_clk) disable iff (rst)
    wrAllowed && (regAddr == ADDR_FREQ3) |=> q_ff.freq[31:24] == $past(regWrData))
    else $error("Frequency byte 15 write not stored.");

  a_freq_lsb_rd: assert property (@(posedge ref_clk) disable iff (rst)
    regRdStb && (regAddr == ADDR_FREQ0) |=> regRdData == $past(q_ff.freq[7:0]))
    else $error("Frequency byte 18 read back wrong.");

  a_soft_rst_clear: assert property (@(posedge ref_clk) disable iff (rst)
    ctrlWr && regWrData[BIT_SOFT_RST]
    |=> (q_ff.freq == FREQ_RST) && !q_ff.holdMult && !q_ff.loopHold && !q_ff.reload)
    else $error("Soft reset left state behind.");

  a_soft_clk_off: assert property (@(posedge ref_clk) disable iff (rst)
    ctrlWr && regWrData[BIT_SOFT_RST] |=> !clkOutOe && serialAbort ##1 !clkOutOe)
    else $error("Clock output driven during soft reset.");

  a_soft_self_clr: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(q_ff.softRst) |-> ##[1:SOFT_MAX] !q_ff.softRst)
    else $error("Soft reset bit did not clear itself.");

  a_soft_wr_drop: assert property (@(posedge ref_clk) disable iff (rst)
    q_ff.softRst && regWrStb && (regAddr == ADDR_LOOP) && !seqBus.softDone |=> !q_ff.loopHold)
    else $error("Write accepted during soft reset.");

  a_strobe_self_clr: assert property (@(posedge ref_clk) disable iff (rst)
    q_ff.freqStrobe && newFreqApplied && !ctrlWr |=> !newFrequencyStrobe)
    else $error("New frequency strobe did not clear.");

  a_strobe_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    ctrlWr && regWrData[BIT_NEW_FREQ] && !regWrData[BIT_SOFT_RST] |=> newFrequencyStrobe)
    else $error("New frequency strobe lost.");

  a_mult_hold: assert property (@(posedge ref_clk) disable iff (rst)
    q_ff.holdMult && !ctrlWr |=> $stable(altReferenceFreqWord))
    else $error("Multiplier word moved while held.");

  a_mult_follow: assert property (@(posedge ref_clk) disable iff (rst)
    !q_ff.holdMult && !ctrlWr |=> altReferenceFreqWord == $past(q_ff.freq))
    else $error("Multiplier word did not follow the frequency word.");

  a_cv_hold: assert property (@(posedge ref_clk) disable iff (rst)
    q_ff.holdCv && !ctrlWr |=> $stable(cvWord))
    else $error("Converter word moved while held.");

  a_reload_copy: assert property (@(posedge ref_clk) disable iff (rst)
    seqBus.reloadDone && !wrAllowed |=> q_ff.freq == $past(nvFreqWord) && !q_ff.reload)
    else $error("Reload did not copy the stored word.");

  a_reload_self_clr: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(q_ff.reload) && !q_ff.softRst |-> ##[1:RELOAD_MAX] !q_ff.reload)
    else $error("Reload bit did not clear itself.");

  // A soft reset written during a reload overlaps it for one cycle before the sequencer switches.
  a_reload_no_abort: assert property (@(posedge ref_clk) disable iff (rst)
    nvReadReq && !$past(ctrlWr && regWrData[BIT_SOFT_RST]) |-> !serialAbort)
    else $error("Reload disturbed the serial interface.");

  a_loop_hold_wr: assert property (@(posedge ref_clk) disable iff (rst)
    loopWr && !regWrData[BIT_SOFT_RST] |=> holdSynthLoop == $past(regWrData[BIT_LOOP_HOLD]))
    else $error("Loop hold bit not applied.");

  a_ctrl_rd_zero: assert property (@(posedge ref_clk) disable iff (rst)
    regRdStb && (regAddr == ADDR_CTRL) |=> regRdData[3:1] == 3'b000)
    else $error("Control register bits 3:1 not zero.");

  a_reset_ctrl: assert property (@(posedge ref_clk)
    $fell(rst) |-> !q_ff.softRst && !q_ff.freqStrobe && !q_ff.reload)
    else $error("Control register not clear after reset.");

endmodule : scrb_bank
`default_nettype wire

// File: design/scrb_pkg.sv
// Constants and types shared by the synthesiser control register bank.
package scrb_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_FREQ3 = 8'h0f;
  localparam logic [7:0] ADDR_FREQ2 = 8'h10;
  localparam logic [7:0] ADDR_FREQ1 = 8'h11;
  localparam logic [7:0] ADDR_FREQ0 = 8'h12;
  localparam logic [7:0] ADDR_CTRL = 8'h87;
  localparam logic [7:0] ADDR_LOOP = 8'h89;

  // Control register and loop register fields.
  localparam int BIT_SOFT_RST = 7;
  localparam int BIT_NEW_FREQ = 6;
  localparam int BIT_HOLD_MULT = 5;
  localparam int BIT_HOLD_CV = 4;
  localparam int BIT_RELOAD = 0;
  localparam int BIT_LOOP_HOLD = 4;

  // Values after reset.
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LOOP_RST = 8'h00;

  // Width of the control-voltage converter word.
  localparam int CV_W = 16;

  // Sequence timing at a 10 ns clock.
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SOFT_RST_NS = 1000;
  localparam int RELOAD_NS = 500;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RELOAD_CYC = (RELOAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEQ_CNT_W = 16;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SOFT = 2'b01,
    SEQ_RELOAD = 2'b10
  } scrb_seq_state_t;

  typedef struct packed {
    scrb_seq_state_t state;
    logic [SEQ_CNT_W-1:0] cnt;
  } scrb_seq_t;

  typedef struct packed {
    logic [31:0] freq;
    logic softRst;
    logic freqStrobe;
    logic holdMult;
    logic holdCv;
    logic reload;
    logic loopHold;
    logic [31:0] multWord;
    logic [CV_W-1:0] cvWord;
    logic [7:0] rdData;
  } scrb_state_t;

endpackage : scrb_pkg

// File: design/scrb_seq_if.sv
// Handshake between the register bank and its reset and reload sequencer.
`timescale 1ns/1ps
`default_nettype none
interface scrb_seq_if;
  logic softReq;
  logic reloadReq;
  logic inSoft;
  logic inReload;
  logic softDone;
  logic reloadDone;
  modport bank (output softReq, output reloadReq,
    input inSoft, input inReload, input softDone, input reloadDone);
  modport seq (input softReq, input reloadReq,
    output inSoft, output inReload, output softDone, output reloadDone);
endinterface : scrb_seq_if
`default_nettype wire

// File: design/scrb_seq.sv
// Timed sequencer for the soft reset and the nonvolatile reload.
`timescale 1ns/1ps
`default_nettype none
module scrb_seq
  import scrb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Bank side.
  scrb_seq_if.seq sq
);

  scrb_seq_t q_ff;
  scrb_seq_t nxt_q;

  ////////////////////////////////////////////////////////////////////////////
  // A soft reset overrides a reload in flight, since it wipes the
  // registers that the reload would fill anyway.
  always_comb begin
    nxt_q = q_ff;
    unique case (q_ff.state)
      SEQ_IDLE: begin
        if (sq.softReq) begin
          nxt_q.state = SEQ_SOFT;
          nxt_q.cnt = SEQ_CNT_W'(SOFT_RST_CYC - 1);
        end else if (sq.reloadReq) begin
          nxt_q.state = SEQ_RELOAD;
          nxt_q.cnt = SEQ_CNT_W'(RELOAD_CYC - 1);
        end
      end
      SEQ_SOFT: begin
        if (q_ff.cnt == '0) begin
          nxt_q.state = SEQ_IDLE;
        end else begin
          nxt_q.cnt = q_ff.cnt - 1'b1;
        end
      end
      SEQ_RELOAD: begin
        if (sq.softReq) begin
          nxt_q.state = SEQ_SOFT;
          nxt_q.cnt = SEQ_CNT_W'(SOFT_RST_CYC - 1);
        end else if (q_ff.cnt == '0) begin
          nxt_q.state = SEQ_IDLE;
        end else begin
          nxt_q.cnt = q_ff.cnt - 1'b1;
        end
      end
      default: begin
        nxt_q.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_ff <= '{state: SEQ_IDLE, cnt: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sq.inSoft = (q_ff.state == SEQ_SOFT);
  assign sq.inReload = (q_ff.state == SEQ_RELOAD);
  assign sq.softDone = (q_ff.state == SEQ_SOFT) && (q_ff.cnt == '0);
  assign sq.reloadDone = (q_ff.state == SEQ_RELOAD) && (q_ff.cnt == '0) && !sq.softReq;

endmodule : scrb_seq
`default_nettype wire

// File: testbench/scrb_far_model.sv
// Far-side model of the synthesis loop, the converter and the nonvolatile store.
`timescale 1ns/1ps
`default_nettype none
module scrb_far_model
  import scrb_pkg::*;
#(
  parameter int APPLY_LAT = 6,
  parameter logic [31:0] NV_WORD = 32'hc0de_0042
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Synthesis loop.
  input wire logic newFrequencyStrobe,
  output logic newFreqApplied,
  // Converter and store.
  output logic [CV_W-1:0] cvSample,
  output logic [31:0] nvFreqWord
);
  int waitCnt;
  assign nvFreqWord = NV_WORD;
  // The loop settles for a while before it confirms, so the strobe is seen high by a polling host.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitCnt <= 0;
      newFreqApplied <= 1'b0;
      cvSample <= 16'h0000;
    end else begin
      cvSample <= cvSample + 16'h0001;
      newFreqApplied <= newFrequencyStrobe && (waitCnt == APPLY_LAT);
      waitCnt <= newFrequencyStrobe ? waitCnt + 1 : 0;
    end
  end
endmodule : scrb_far_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking testbench of the synthesiser control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scrb_pkg::*;
  localparam logic [31:0] NV_WORD = 32'hc0de_0042;
  localparam logic [31:0] WORD = 32'h1234_5678;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWrStb = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRdStb = 1'b0;
  logic [7:0] regRdData;
  logic serialAbort, newFrequencyStrobe, newFreqApplied, holdSynthLoop, nvReadReq, clkOutOe;
  logic [31:0] altReferenceFreqWord, nvFreqWord;
  logic [CV_W-1:0] cvSample, cvWord, cvKeep;
  int mismatches = 0;
  int checked = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  scrb_bank scrb_bank_inst (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrStb(regWrStb),
    .regWrData(regWrData), .regRdStb(regRdStb), .regRdData(regRdData), .serialAbort(serialAbort),
    .altReferenceFreqWord(altReferenceFreqWord), .newFrequencyStrobe(newFrequencyStrobe),
    .newFreqApplied(newFreqApplied), .holdSynthLoop(holdSynthLoop), .cvSample(cvSample), .cvWord(cvWord),
    .nvReadReq(nvReadReq), .nvFreqWord(nvFreqWord), .clkOutOe(clkOutOe));
  scrb_far_model #(.NV_WORD(NV_WORD)) scrb_far_model_inst (.ref_clk(ref_clk), .rst(rst),
    .newFrequencyStrobe(newFrequencyStrobe), .newFreqApplied(newFreqApplied), .cvSample(cvSample),
    .nvFreqWord(nvFreqWord));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic miss(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : miss
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    miss({24'h00_0000, got}, {24'h00_0000, exp});
  endtask : chkByte
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    miss(got, exp);
  endtask : chkWord
  task automatic chkFlag(input logic got, input logic exp);
    miss({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask : chkFlag
  task automatic waitCyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask : waitCyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrStb = 1'b1;
    @(negedge ref_clk);
    regWrStb = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regRdStb = 1'b1;
    @(negedge ref_clk);
    regRdStb = 1'b0;
    d = regRdData;
  endtask : rd
  task automatic chkRd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chkByte(d, exp);
  endtask : chkRd
  // Polls the control register for a self-clearing bit, giving up after 300 reads.
  task automatic pollClear(input int b);
    logic [7:0] d;
    int k;
    d = 8'hff;
    k = 0;
    while (d[b] !== 1'b0 && k < 300) begin
      rd(ADDR_CTRL, d);
      k++;
    end
    chkFlag(d[b], 1'b0);
  endtask : pollClear
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  // The whole sequence needs well under 1000 cycles; the watchdog allows several times that before declaring a hang.
  initial begin
    #75000;
    mismatches++;
    complete_run();
  end
  initial begin
    waitCyc(10);
    rst = 1'b0;
    chkRd(ADDR_CTRL, CTRL_RST);
    chkRd(ADDR_LOOP, LOOP_RST);
    chkRd(8'h20, 8'h00);
    chkFlag(clkOutOe, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) wr(8'(ADDR_FREQ3 + i), WORD[8*(3-i) +: 8]);
    for (int i = 0; i < 4; i++) chkRd(8'(ADDR_FREQ3 + i), WORD[8*(3-i) +: 8]);
    chkWord(altReferenceFreqWord, WORD);
    $display("test frequency word done");
    wr(ADDR_CTRL, 8'h20);
    wr(ADDR_FREQ3, 8'haa);
    waitCyc(3);
    chkWord(altReferenceFreqWord, WORD);
    chkRd(ADDR_FREQ3, 8'haa);
    wr(ADDR_CTRL, 8'h00);
    waitCyc(2);
    chkWord(altReferenceFreqWord, {8'haa, WORD[23:0]});
    $display("test multiplier hold done");
    wr(ADDR_CTRL, 8'h10);
    waitCyc(1);
    cvKeep = cvWord;
    waitCyc(3);
    chkWord(32'(cvWord), 32'(cvKeep));
    chkRd(ADDR_CTRL, 8'h10);
    wr(ADDR_CTRL, 8'h00);
    waitCyc(2);
    chkFlag(logic'(cvWord != cvKeep), 1'b1);
    $display("test converter hold done");
    wr(ADDR_LOOP, 8'hff);
    chkFlag(holdSynthLoop, 1'b1);
    chkRd(ADDR_LOOP, 8'h10);
    wr(ADDR_FREQ0, 8'h5a);
    wr(ADDR_LOOP, 8'h00);
    chkFlag(holdSynthLoop, 1'b0);
    wr(ADDR_CTRL, 8'h40);
    chkFlag(newFrequencyStrobe, 1'b1);
    pollClear(BIT_NEW_FREQ);
    chkFlag(newFrequencyStrobe, 1'b0);
    $display("test retune done");
    wr(ADDR_CTRL, 8'h00);
    waitCyc(2);
    chkFlag(nvReadReq, 1'b0);
    wr(ADDR_CTRL, 8'h01);
    waitCyc(1);
    chkFlag(nvReadReq, 1'b1);
    chkFlag(serialAbort, 1'b0);
    // A written zero must leave the reload in flight running.
    wr(ADDR_CTRL, 8'h00);
    chkRd(ADDR_CTRL, 8'h01);
    chkFlag(nvReadReq, 1'b1);
    pollClear(BIT_RELOAD);
    waitCyc(2);
    chkWord(altReferenceFreqWord, NV_WORD);
    $display("test reload done");
    // The soft reset lands in the middle of a reload, which it must cut short.
    wr(ADDR_LOOP, 8'h10);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_CTRL, 8'h80);
    chkFlag(serialAbort, 1'b1);
    chkFlag(clkOutOe, 1'b0);
    wr(ADDR_FREQ3, 8'h55);
    wr(ADDR_LOOP, 8'h10);
    n = 0;
    while (serialAbort !== 1'b0 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    chkFlag(serialAbort, 1'b0);
    chkFlag(clkOutOe, 1'b1);
    chkFlag(holdSynthLoop, 1'b0);
    chkFlag(nvReadReq, 1'b0);
    chkRd(ADDR_CTRL, CTRL_RST);
    chkRd(ADDR_FREQ3, FREQ_RST[31:24]);
    chkWord(altReferenceFreqWord, FREQ_RST);
    $display("test soft reset done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
